// *** pkg/udrt_pkg.sv ***
// package for the up/down auto-reload 8-bit timer: register map, fields, resets
package udrt_pkg;
    // printed offsets are not all multiples of four: these are indices, byte address = 4*index
    localparam logic [15:0] UDRT_IDX_MODE     = 16'hffb4;
    localparam logic [15:0] UDRT_IDX_COUNT    = 16'hffb5;
    localparam logic [15:0] UDRT_IDX_IRQ_STAT = 16'hffc0;
    localparam logic [15:0] UDRT_IDX_IRQ_EN   = 16'hffc1;
    localparam logic [15:0] UDRT_IDX_IRQ_CLR  = 16'hffc2;
    localparam logic [15:0] UDRT_IDX_PINCTL   = 16'hffc3;

    // mode register fields
    localparam int UDRT_MODE_RELOAD_BIT = 7;
    localparam int UDRT_MODE_PINDIR_BIT = 6;
    localparam int UDRT_MODE_SOFTDIR_BIT = 5;
    localparam logic [7:0] UDRT_MODE_RSVD_MASK  = 8'h18;
    localparam logic [7:0] UDRT_MODE_RESET      = 8'h18;
    localparam logic [7:0] UDRT_COUNT_RESET     = 8'h00;
    localparam logic [7:0] UDRT_RELOAD_RESET    = 8'h00;
    localparam logic [7:0] UDRT_COUNT_MAX       = 8'hff;
    localparam logic [7:0] UDRT_COUNT_MIN       = 8'h00;

    // pin control register fields
    localparam int UDRT_PINCTL_EDGE_BIT = 0;
    localparam int UDRT_PINCTL_LOWPWR_BIT = 1;

    // clock select codes
    typedef enum logic [2:0] {
        UDRT_CS_DIV8192 = 3'b000,
        UDRT_CS_DIV2048 = 3'b001,
        UDRT_CS_DIV512  = 3'b010,
        UDRT_CS_DIV64   = 3'b011,
        UDRT_CS_DIV16   = 3'b100,
        UDRT_CS_DIV4    = 3'b101,
        UDRT_CS_SUBDIV4 = 3'b110,
        UDRT_CS_EVENT   = 3'b111
    } udrt_clksel_t;

    localparam int UDRT_PRESCALE_W = 13;
    localparam logic [31:0] UDRT_APB_ERR_NONE = 32'h0000_0000;
endpackage : udrt_pkg

// *** rtl/udrt_timer.sv ***
// up/down auto-reload 8-bit timer with apb register slave
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - eight-bit counter steps up/down per selected pulse
// - mode bit 7 picks interval or reload
// - direction bits: 00 up, 01 down, 1x pin
// - pin high counts down, low counts up
// - mode bits 4,3 read one, ignore writes
// - clock select picks prescaler, subclock or events
// - event edge rising or falling by select bit
// - counter readable any time without disturbance
// - overflow or underflow sets interrupt flag
// - shared address: read counter, write reload
// - reload write also loads counter at once
// - reload mode reloads on wrap, interval wraps
// - reset: mode 18, counter and reload zero
// - low power: count only on subclock or events
// - interrupt only when interrupt enable bit set
module udrt_timer
    import udrt_pkg::*;
(
    input  wire logic        core_clk,        // system clock, 40 MHz
    input  wire logic        resetn,          // async reset, active low
    input  wire logic        psel,            // apb select
    input  wire logic        penable,         // apb access phase
    input  wire logic        pwrite,          // apb direction
    input  wire logic [17:0] paddr,           // apb byte address
    input  wire logic [31:0] pwdata,          // apb write data
    output logic             pready,          // apb ready
    output logic      [31:0] prdata,          // apb read data
    output logic             pslverr,         // apb error
    input  wire logic        event_input_pin, // external event pin
    input  wire logic        count_direction_pin, // direction pin, high = down
    input  wire logic        sub_clk_div4,    // subclock-derived clock, async
    input  wire logic        low_power_mode,  // subclock-based low-power mode level
    output logic             timer_irq        // level interrupt
);

    // ==========================================================
    // synchronisers
    logic [2:0] ev_sync_r,  ev_sync_nxt;
    logic [2:0] sub_sync_r, sub_sync_nxt;
    logic [1:0] dir_sync_r, dir_sync_nxt;
    logic [1:0] lp_sync_r,  lp_sync_nxt;

    always_comb begin
        // stage 0 feeds only stage 1; edge logic looks at stages 1 and 2
        ev_sync_nxt  = {ev_sync_r[1:0], event_input_pin};
        sub_sync_nxt = {sub_sync_r[1:0], sub_clk_div4};
        dir_sync_nxt = {dir_sync_r[0], count_direction_pin};
        lp_sync_nxt  = {lp_sync_r[0], low_power_mode};
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ev_sync_r  <= 3'b000;
            sub_sync_r <= 3'b000;
            dir_sync_r <= 2'b00;
            lp_sync_r  <= 2'b00;
        end else begin
            ev_sync_r  <= ev_sync_nxt;
            sub_sync_r <= sub_sync_nxt;
            dir_sync_r <= dir_sync_nxt;
            lp_sync_r  <= lp_sync_nxt;
        end
    end

    // ==========================================================
    // registers
    logic [7:0]  mode_r,   mode_nxt;
    logic [7:0]  count_r,  count_nxt;
    logic [7:0]  reload_r, reload_nxt;
    logic        stat_r,   stat_nxt;
    logic        irq_en_r, irq_en_nxt;
    logic [1:0]  pinctl_r, pinctl_nxt;
    logic [UDRT_PRESCALE_W-1:0] pre_r, pre_nxt;
    logic        irq_r,    irq_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic [31:0] rd_word;

    logic        wr_en;
    logic        rd_en;
    logic [15:0] widx;
    logic        hit;
    logic        tick;
    logic        down;
    logic        wrap;
    logic        ev_rise;
    logic        ev_fall;
    logic        sub_rise;
    logic        src_pulse;
    logic        lp_ok;
    udrt_clksel_t csel;

    assign widx  = paddr[17:2];
    assign wr_en = psel && penable && pwrite;
    // reads are caught at the setup edge so the data can come from a flop
    assign rd_en = psel && !penable && !pwrite;
    assign csel  = udrt_clksel_t'(mode_r[2:0]);
    assign ev_rise  = ev_sync_r[1] && !ev_sync_r[2];
    assign ev_fall  = !ev_sync_r[1] && ev_sync_r[2];
    assign sub_rise = sub_sync_r[1] && !sub_sync_r[2];

    always_comb begin
        pre_nxt = pre_r + {{(UDRT_PRESCALE_W-1){1'b0}}, 1'b1};
        // prescaler taps pulse once per divide period
        unique case (csel)
            UDRT_CS_DIV8192: src_pulse = (pre_r[12:0] == 13'h1fff);
            UDRT_CS_DIV2048: src_pulse = (pre_r[10:0] == 11'h7ff);
            UDRT_CS_DIV512:  src_pulse = (pre_r[8:0] == 9'h1ff);
            UDRT_CS_DIV64:   src_pulse = (pre_r[5:0] == 6'h3f);
            UDRT_CS_DIV16:   src_pulse = (pre_r[3:0] == 4'hf);
            UDRT_CS_DIV4:    src_pulse = (pre_r[1:0] == 2'h3);
            UDRT_CS_SUBDIV4: src_pulse = sub_rise;
            UDRT_CS_EVENT:   src_pulse = pinctl_r[UDRT_PINCTL_EDGE_BIT] ? ev_rise : ev_fall;
        endcase
    end

    // in low power only the subclock and event sources keep running
    assign lp_ok = !lp_sync_r[1] || (csel == UDRT_CS_SUBDIV4) || (csel == UDRT_CS_EVENT);
    assign tick  = src_pulse && lp_ok;

    always_comb begin
        if (mode_r[UDRT_MODE_PINDIR_BIT]) begin
            down = dir_sync_r[1];
        end else begin
            down = mode_r[UDRT_MODE_SOFTDIR_BIT];
        end
    end

    assign wrap = tick && (down ? (count_r == UDRT_COUNT_MIN) : (count_r == UDRT_COUNT_MAX));
    assign hit  = wr_en && (widx == UDRT_IDX_COUNT);

    always_comb begin
        mode_nxt   = mode_r;
        reload_nxt = reload_r;
        irq_en_nxt = irq_en_r;
        pinctl_nxt = pinctl_r;
        count_nxt  = count_r;
        if (wr_en && widx == UDRT_IDX_MODE) begin
            mode_nxt = (pwdata[7:0] & ~UDRT_MODE_RSVD_MASK) | UDRT_MODE_RSVD_MASK;
        end
        if (wr_en && widx == UDRT_IDX_IRQ_EN) begin
            irq_en_nxt = pwdata[0];
        end
        if (wr_en && widx == UDRT_IDX_PINCTL) begin
            pinctl_nxt = pwdata[1:0];
        end
        if (hit) begin
            reload_nxt = pwdata[7:0];
            count_nxt  = pwdata[7:0];
        end else if (wrap && mode_r[UDRT_MODE_RELOAD_BIT]) begin
            count_nxt = reload_r;
        end else if (tick) begin
            count_nxt = down ? count_r - 8'h01 : count_r + 8'h01;
        end
        // a wrap in the same cycle as a clear still sets the flag
        stat_nxt = stat_r;
        if (wr_en && widx == UDRT_IDX_IRQ_CLR && pwdata[0]) begin
            stat_nxt = 1'b0;
        end
        if (wrap) begin
            stat_nxt = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mode_r   <= UDRT_MODE_RESET;
            count_r  <= UDRT_COUNT_RESET;
            reload_r <= UDRT_RELOAD_RESET;
            stat_r   <= 1'b0;
            irq_en_r <= 1'b0;
            pinctl_r <= 2'b00;
            pre_r    <= '0;
        end else begin
            mode_r   <= mode_nxt;
            count_r  <= count_nxt;
            reload_r <= reload_nxt;
            stat_r   <= stat_nxt;
            irq_en_r <= irq_en_nxt;
            pinctl_r <= pinctl_nxt;
            pre_r    <= pre_nxt;
        end
    end

    // interrupt level is registered so the pin never glitches on a clear
    always_comb begin
        irq_nxt = stat_nxt && irq_en_nxt;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    assign timer_irq = irq_r;

    // ==========================================================
    // apb read side: zero wait states, reads have no side effects
    // read data is caught at the setup edge so prdata comes from a flop;
    // a count read therefore shows the value one cycle before the access
    always_comb begin
        rd_word = UDRT_APB_ERR_NONE;
        unique case (widx)
            UDRT_IDX_MODE:     rd_word = {24'h00_0000, mode_r};
            UDRT_IDX_COUNT:    rd_word = {24'h00_0000, count_r};
            UDRT_IDX_IRQ_STAT: rd_word = {31'h0, stat_r};
            UDRT_IDX_IRQ_EN:   rd_word = {31'h0, irq_en_r};
            UDRT_IDX_PINCTL:   rd_word = {30'h0, pinctl_r};
            default:           rd_word = UDRT_APB_ERR_NONE;
        endcase
        prdata_nxt = prdata_r;
        if (psel && penable) begin
            prdata_nxt = UDRT_APB_ERR_NONE;
        end
        if (rd_en) begin
            prdata_nxt = rd_word;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prdata_r <= UDRT_APB_ERR_NONE;
        end else begin
            prdata_r <= prdata_nxt;
        end
    end

    assign prdata = prdata_r;

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !(widx == UDRT_IDX_MODE || widx == UDRT_IDX_COUNT
                     || widx == UDRT_IDX_IRQ_STAT || widx == UDRT_IDX_IRQ_EN
                     || widx == UDRT_IDX_IRQ_CLR || widx == UDRT_IDX_PINCTL);

    // ==========================================================
    // assertions
    sequence wrap_up_s;
        tick && !down && count_r == 8'hff && !hit;
    endsequence

    sequence wrap_dn_s;
        tick && down && count_r == UDRT_COUNT_MIN && !hit;
    endsequence

    sequence rd_setup_s;
        psel && !penable && !pwrite;
    endsequence

    sequence access_s;
        psel && penable;
    endsequence

    reload_wrap_a: assert property (@(posedge core_clk) disable iff (!resetn)
        wrap_up_s and mode_r[7] |=> count_r == $past(reload_r))
        else $error("reload not taken on wrap");

    interval_wrap_a: assert property (@(posedge core_clk) disable iff (!resetn)
        wrap_up_s and !mode_r[7] |=> count_r == 8'h00)
        else $error("interval wrap not to zero");

    flag_set_a: assert property (@(posedge core_clk) disable iff (!resetn)
        wrap |=> stat_r)
        else $error("wrap did not set flag");

    load_write_a: assert property (@(posedge core_clk) disable iff (!resetn)
        hit |=> count_r == $past(pwdata[7:0]) && reload_r == $past(pwdata[7:0]))
        else $error("load write not copied to counter");

    rsvd_bits_a: assert property (@(posedge core_clk) disable iff (!resetn)
        mode_r[4:3] == 2'b11)
        else $error("reserved mode bits not one");

    down_step_a: assert property (@(posedge core_clk) disable iff (!resetn)
        tick && mode_r[6] && dir_sync_r[1] && !hit && count_r != 8'h00
        |=> count_r == $past(count_r) - 8'h01)
        else $error("pin high did not count down");

    idle_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
        !tick && !hit |=> $stable(count_r))
        else $error("counter moved without a pulse");

    irq_gate_a: assert property (@(posedge core_clk) disable iff (!resetn)
        timer_irq == (stat_r && irq_en_r))
        else $error("interrupt not gated by enable");

    lowpower_a: assert property (@(posedge core_clk) disable iff (!resetn)
        lp_sync_r[1] && csel != UDRT_CS_EVENT && csel != UDRT_CS_SUBDIV4 |-> !tick)
        else $error("counted in low power");

    under_wrap_a: assert property (@(posedge core_clk) disable iff (!resetn)
        wrap_dn_s and !mode_r[UDRT_MODE_RELOAD_BIT] |=> count_r == UDRT_COUNT_MAX)
        else $error("interval underflow not to ff");

    under_reload_a: assert property (@(posedge core_clk) disable iff (!resetn)
        wrap_dn_s and mode_r[UDRT_MODE_RELOAD_BIT] |=> count_r == $past(reload_r))
        else $error("reload not taken on underflow");

    up_step_a: assert property (@(posedge core_clk) disable iff (!resetn)
        tick && !down && !hit && count_r != UDRT_COUNT_MAX
        |=> count_r == $past(count_r) + 8'h01)
        else $error("up count did not step by one");

    soft_down_a: assert property (@(posedge core_clk) disable iff (!resetn)
        tick && !mode_r[UDRT_MODE_PINDIR_BIT] && mode_r[UDRT_MODE_SOFTDIR_BIT] && !hit
        && count_r != UDRT_COUNT_MIN |=> count_r == $past(count_r) - 8'h01)
        else $error("software down count did not step");

    pin_up_a: assert property (@(posedge core_clk) disable iff (!resetn)
        tick && mode_r[UDRT_MODE_PINDIR_BIT] && !dir_sync_r[1] && !hit
        && count_r != UDRT_COUNT_MAX |=> count_r == $past(count_r) + 8'h01)
        else $error("pin low did not count up");

    flag_sticky_a: assert property (@(posedge core_clk) disable iff (!resetn)
        stat_r && !(wr_en && widx == UDRT_IDX_IRQ_CLR && pwdata[0]) |=> stat_r)
        else $error("flag dropped without a clear");

    flag_clear_a: assert property (@(posedge core_clk) disable iff (!resetn)
        wr_en && widx == UDRT_IDX_IRQ_CLR && pwdata[0] && !wrap |=> !stat_r)
        else $error("flag not cleared by write");

    edge_single_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (ev_rise |=> !ev_rise) and (ev_fall |=> !ev_fall) and (sub_rise |=> !sub_rise))
        else $error("count enable wider than one cycle");

    count_read_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (rd_setup_s and widx == UDRT_IDX_COUNT) ##1 access_s
        |-> prdata == {24'h00_0000, $past(count_r)})
        else $error("count read returned wrong value");

    mode_write_a: assert property (@(posedge core_clk) disable iff (!resetn)
        wr_en && widx == UDRT_IDX_MODE |=> mode_r[7:5] == $past(pwdata[7:5])
        && mode_r[2:0] == $past(pwdata[2:0]))
        else $error("mode write not stored");

    reload_keep_a: assert property (@(posedge core_clk) disable iff (!resetn)
        !hit |=> $stable(reload_r))
        else $error("reload changed without a write");

endmodule : udrt_timer
`default_nettype wire

// *** sim/test_udrt_timer.sv ***
// self-checking bench for the up/down reload timer
`timescale 1ns/1ps
`default_nettype none
module test_udrt_timer;
    import udrt_pkg::*;
    logic core_clk, resetn, psel, penable, pwrite, pready, pslverr, timer_irq;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata;
    logic ev_lvl, dir_lvl, lp_lvl, ev_pin, dir_pin, sub_clk, lp_pin, last_err;
    logic [7:0] got;
    int failures, tests_run, cycles;
    udrt_timer dut (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .event_input_pin(ev_pin), .count_direction_pin(dir_pin),
        .sub_clk_div4(sub_clk), .low_power_mode(lp_pin), .timer_irq(timer_irq));
    udrt_pin_model pins (.core_clk(core_clk), .ev_lvl(ev_lvl), .dir_lvl(dir_lvl),
        .lp_lvl(lp_lvl), .event_input_pin(ev_pin), .count_direction_pin(dir_pin),
        .sub_clk_div4(sub_clk), .low_power_mode(lp_pin));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // ==========================================
    // tasks
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : close_out
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // one apb transfer; request held until pready is seen at a rising edge
    task automatic xfer(input logic [15:0] idx, input logic wr, input logic [7:0] d);
        @(posedge core_clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h00_0000, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        got      = prdata[7:0];
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        xfer(idx, 1'b1, d);
    endtask : wr
    task automatic rd(input logic [15:0] idx, input logic [7:0] e);
        xfer(idx, 1'b0, 8'h00);
        chk(got, e);
    endtask : rd
    task automatic waitc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : waitc
    // the interrupt level moves at the edge that takes the write, so look one edge later
    task automatic irq_is(input logic e);
        waitc(1);
        chk({7'h00, timer_irq}, {7'h00, e});
    endtask : irq_is
    // event pulses; each gives one rising and one falling edge
    task automatic ev(input int n);
        repeat (n) begin
            ev_lvl <= 1'b1;
            waitc(8);
            ev_lvl <= 1'b0;
            waitc(8);
        end
    endtask : ev
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            close_out();
        end
    end
    // ==========================================
    // main sequence
    initial begin
        {psel, penable, pwrite, ev_lvl, dir_lvl, lp_lvl, resetn} = '0;
        paddr = '0;
        pwdata = '0;
        failures = 0;
        tests_run = 0;
        cycles = 0;
        waitc(8);
        resetn <= 1'b1;
        rd(UDRT_IDX_MODE, 8'h18);
        rd(UDRT_IDX_COUNT, 8'h00);
        wr(UDRT_IDX_MODE, 8'h00);
        rd(UDRT_IDX_MODE, 8'h18);
        wr(UDRT_IDX_PINCTL, 8'h01);
        wr(UDRT_IDX_MODE, 8'h07);
        wr(UDRT_IDX_COUNT, 8'hfd);
        rd(UDRT_IDX_COUNT, 8'hfd);
        rd(UDRT_IDX_COUNT, 8'hfd);
        ev(3);
        rd(UDRT_IDX_COUNT, 8'h00);
        rd(UDRT_IDX_IRQ_STAT, 8'h01);
        irq_is(1'b0);
        wr(UDRT_IDX_IRQ_EN, 8'h01);
        irq_is(1'b1);
        wr(UDRT_IDX_IRQ_CLR, 8'h01);
        irq_is(1'b0);
        wr(UDRT_IDX_MODE, 8'h87);
        wr(UDRT_IDX_COUNT, 8'hfe);
        ev(2);
        rd(UDRT_IDX_COUNT, 8'hfe);
        rd(UDRT_IDX_IRQ_STAT, 8'h01);
        wr(UDRT_IDX_IRQ_CLR, 8'h01);
        wr(UDRT_IDX_MODE, 8'h27);
        wr(UDRT_IDX_COUNT, 8'h01);
        ev(2);
        rd(UDRT_IDX_COUNT, 8'hff);
        rd(UDRT_IDX_IRQ_STAT, 8'h01);
        irq_is(1'b1);
        wr(UDRT_IDX_MODE, 8'ha7);
        wr(UDRT_IDX_COUNT, 8'h02);
        ev(3);
        rd(UDRT_IDX_COUNT, 8'h02);
        dir_lvl <= 1'b1;
        wr(UDRT_IDX_MODE, 8'h47);
        wr(UDRT_IDX_COUNT, 8'h05);
        ev(1);
        rd(UDRT_IDX_COUNT, 8'h04);
        dir_lvl <= 1'b0;
        wr(UDRT_IDX_MODE, 8'h67);
        ev(2);
        rd(UDRT_IDX_COUNT, 8'h06);
        wr(UDRT_IDX_PINCTL, 8'h00);
        wr(UDRT_IDX_COUNT, 8'h10);
        ev_lvl <= 1'b1;
        waitc(8);
        rd(UDRT_IDX_COUNT, 8'h10);
        ev_lvl <= 1'b0;
        waitc(8);
        rd(UDRT_IDX_COUNT, 8'h11);
        lp_lvl <= 1'b1;
        ev(1);
        rd(UDRT_IDX_COUNT, 8'h12);
        wr(UDRT_IDX_MODE, 8'h05);
        wr(UDRT_IDX_COUNT, 8'h20);
        waitc(40);
        rd(UDRT_IDX_COUNT, 8'h20);
        wr(UDRT_IDX_MODE, 8'h06);
        waitc(200);
        xfer(UDRT_IDX_COUNT, 1'b0, 8'h00);
        chk({7'h00, got > 8'h20}, 8'h01);
        lp_lvl <= 1'b0;
        wr(UDRT_IDX_MODE, 8'h05);
        wr(UDRT_IDX_COUNT, 8'h20);
        waitc(40);
        xfer(UDRT_IDX_COUNT, 1'b0, 8'h00);
        chk({7'h00, got > 8'h20}, 8'h01);
        rd(16'hffb0, 8'h00);
        chk({7'h00, last_err}, 8'h01);
        // a second reset in mid-run must bring back the reset values
        resetn <= 1'b0;
        waitc(2);
        resetn <= 1'b1;
        rd(UDRT_IDX_MODE, 8'h18);
        rd(UDRT_IDX_COUNT, 8'h00);
        irq_is(1'b0);
        close_out();
    end
endmodule : test_udrt_timer
`default_nettype wire

// *** sim/udrt_pin_model.sv ***
// far-side pin model: event, direction, low-power pins and a free-running subclock
`timescale 1ns/1ps
`default_nettype none
module udrt_pin_model #(
    parameter int SUB_HALF_NS = 137 // subclock half period, unrelated to core_clk
) (
    input  wire logic core_clk,            // system clock
    input  wire logic ev_lvl,              // requested event level
    input  wire logic dir_lvl,             // requested direction level
    input  wire logic lp_lvl,              // requested low-power level
    output logic      event_input_pin,     // event pin
    output logic      count_direction_pin, // direction pin
    output logic      sub_clk_div4,        // subclock-derived clock
    output logic      low_power_mode       // low-power level
);
    // event, direction and low-power pins move only after the clock edge, as a real port would
    always_ff @(posedge core_clk) begin
        event_input_pin     <= ev_lvl;
        count_direction_pin <= dir_lvl;
        low_power_mode      <= lp_lvl;
    end
    initial begin
        sub_clk_div4 = 1'b0;
        forever #(SUB_HALF_NS) sub_clk_div4 = ~sub_clk_div4;
    end
endmodule : udrt_pin_model
`default_nettype wire
